/* File: logic/hmd_mac_datapath.v */
// halfword multiply-accumulate datapath with its flag updates
// assumes decode supplies one operation per valid cycle, same clock
// Summary of operation
// RL1: low-halfword accumulate multiplies the low halves of both sources and adds the destination.
// RL2: modulo forms write the low 32 bits of the 33-bit sum and drop the top bit.
// RL3: saturating forms write the low 32 bits unless overflowed, else the nearest value.
// RL4: low-halfword accumulate also has unsigned modulo and saturating forms.
// RL5: record forms without overflow enable update condition field zero only.
// RL6: overflow-enabled forms without record update overflow and summary overflow only.
// RL7: overflow-enabled record forms update both flags and condition field zero together.
// RL8: plain forms write only the destination and leave all flags alone.
// RL9: negative cross multiplies low half of first by high half of second, signed.
// RL10: negative forms subtract the product from the destination in 33 bits.
// RL11: negative high multiplies the high halves of both sources, signed.
// RL12: negative forms are signed only, modulo or saturating, with all four flag forms.
// RL13: signed saturation clamps by direction, unsigned saturation clamps to all ones.
// RL14: overflow tracks the 33-bit result each time, summary overflow only ever sets.
`timescale 1ns/10ps
`include "hmd_defines.vh"

module hmd_mac_datapath (
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire op_valid,
  input wire [`HMD_FAM_W-1:0] op_family,
  input wire op_unsigned,
  input wire op_saturate,
  input wire op_record,
  input wire op_oe,
  input wire [`HMD_WORD_W-1:0] first_source_operand,
  input wire [`HMD_WORD_W-1:0] second_source_operand,
  input wire [`HMD_WORD_W-1:0] dest_value,
  input wire xer_wr_en,
  input wire xer_wr_ov,
  input wire xer_wr_so,
  output reg dest_we_q,
  output reg [`HMD_WORD_W-1:0] dest_result_q,
  output reg cr0_we_q,
  output reg [`HMD_CR_W-1:0] condition_field_zero_q,
  output reg xer_we_q,
  output reg overflow_flag_q,
  output reg summary_overflow_q,
  output reg op_reject_q
);

  // pick the requested halfword of a source word
  function [`HMD_HALF_W-1:0] half_sel;
    input [`HMD_WORD_W-1:0] word;
    input upper;
    begin
      if (upper) begin
        half_sel = word[`HMD_HI_HI:`HMD_HI_LO];
      end else begin
        half_sel = word[`HMD_LO_HI:`HMD_LO_LO];
      end
    end
  endfunction

  // condition field from a signed view of the written word
  function [`HMD_CR_W-1:0] cr_of;
    input [`HMD_WORD_W-1:0] value;
    input so_bit;
    reg [`HMD_CR_W-1:0] c;
    begin
      c = `HMD_CR_RST;
      if (value == `HMD_WORD_RST) begin
        c[`HMD_CR_EQ] = 1'b1;
      end else if (value[`HMD_WORD_W-1]) begin
        c[`HMD_CR_LT] = 1'b1;
      end else begin
        c[`HMD_CR_GT] = 1'b1;
      end
      c[`HMD_CR_SO] = so_bit;
      cr_of = c;
    end
  endfunction

  reg a_upper;
  reg b_upper;
  reg neg_op;
  reg legal;
  wire [`HMD_HALF_W-1:0] mult_a;
  wire [`HMD_HALF_W-1:0] mult_b;
  wire [`HMD_WORD_W-1:0] arith_result;
  wire arith_ovf;
  wire is_unsigned;
  wire accept;
  reg ov_d;
  reg so_d;
  wire [`HMD_CR_W-1:0] cr_d;
  wire dest_we_d;
  wire cr0_we_d;
  wire xer_we_d;
  wire reject_d;
  wire form_plain;
  wire form_record_only;
  wire form_oe_only;
  wire form_record_oe;

  // family decode into halfword picks and add or subtract
  always @* begin
    a_upper = 1'b0;
    b_upper = 1'b0;
    neg_op = 1'b0;
    legal = 1'b1;
    case (op_family)
      `HMD_FAM_LOW_ACC: begin
        a_upper = 1'b0; // RL1
        b_upper = 1'b0; // RL1
      end
      `HMD_FAM_NEG_CROSS: begin
        a_upper = 1'b0; // RL9
        b_upper = 1'b1; // RL9
        neg_op = 1'b1; // RL10
        legal = ~op_unsigned; // RL12
      end
      `HMD_FAM_NEG_HIGH: begin
        a_upper = 1'b1; // RL11
        b_upper = 1'b1; // RL11
        neg_op = 1'b1; // RL10
        legal = ~op_unsigned; // RL12
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  assign mult_a = half_sel(first_source_operand, a_upper);
  assign mult_b = half_sel(second_source_operand, b_upper);
  // negative families never run unsigned, even if the decode asks
  assign is_unsigned = op_unsigned & ~neg_op; // RL12
  assign accept = op_valid & legal;

  hmd_mac_arith u_arith (
    .mult_a(mult_a),
    .mult_b(mult_b),
    .accum(dest_value),
    .is_unsigned(is_unsigned),
    .negate(neg_op),
    .saturate(op_saturate),
    .result(arith_result),
    .ovf(arith_ovf)
  );

  // flag next values; an operation that sets summary overflow beats a
  // software clear in the same cycle so no overflow event is lost
  always @* begin
    ov_d = overflow_flag_q;
    so_d = summary_overflow_q;
    if (xer_wr_en) begin
      ov_d = xer_wr_ov;
      so_d = xer_wr_so;
    end
    if (accept && op_oe) begin
      ov_d = arith_ovf; // RL6 RL7 RL14
      if (arith_ovf) begin
        so_d = 1'b1; // RL14
      end
    end
  end
  // the condition field carries the summary overflow as it stands after this op
  assign cr_d = cr_of(arith_result, so_d); // RL5 RL7

  // record and overflow enable are independent bits, so an accepted
  // op falls in exactly one of the four flag forms
  assign form_plain = accept & ~op_record & ~op_oe; // RL8
  assign form_record_only = accept & op_record & ~op_oe; // RL5
  assign form_oe_only = accept & ~op_record & op_oe; // RL6
  assign form_record_oe = accept & op_record & op_oe; // RL7
  // strobe next values, one per written target
  assign dest_we_d = form_plain | form_record_only | form_oe_only | form_record_oe; // RL8
  assign cr0_we_d = form_record_only | form_record_oe; // RL5 RL7
  assign xer_we_d = form_oe_only | form_record_oe; // RL6 RL7
  assign reject_d = op_valid & ~legal; // RL12

  // write strobes last exactly one enabled cycle
  always @(posedge clock) begin
    if (rst) begin
      dest_we_q <= `HMD_BIT_RST;
      cr0_we_q <= `HMD_BIT_RST;
      xer_we_q <= `HMD_BIT_RST;
      op_reject_q <= `HMD_BIT_RST;
    end else if (clk_en) begin
      dest_we_q <= dest_we_d; // RL8
      cr0_we_q <= cr0_we_d; // RL5 RL7 RL8
      xer_we_q <= xer_we_d; // RL6 RL7 RL8
      op_reject_q <= reject_d; // RL12
    end
  end

  // result holds between operations so the core may read it late
  always @(posedge clock) begin
    if (rst) begin
      dest_result_q <= `HMD_WORD_RST;
    end else if (clk_en && dest_we_d) begin
      dest_result_q <= arith_result; // RL2 RL3 RL8
    end
  end

  // condition field only moves on record forms
  always @(posedge clock) begin
    if (rst) begin
      condition_field_zero_q <= `HMD_CR_RST;
    end else if (clk_en && cr0_we_d) begin
      condition_field_zero_q <= cr_d; // RL5 RL7
    end
  end

  // flags move on overflow forms or a software write, never otherwise
  always @(posedge clock) begin
    if (rst) begin
      overflow_flag_q <= `HMD_BIT_RST;
      summary_overflow_q <= `HMD_BIT_RST;
    end else if (clk_en) begin
      overflow_flag_q <= ov_d; // RL6 RL8
      summary_overflow_q <= so_d; // RL6 RL8
    end
  end

endmodule

/* File: common/hmd_defines.vh */
// constants shared by the halfword multiply-accumulate datapath
// assumes inclusion by bare name from every design file of the block
`ifndef HMD_DEFINES_VH
`define HMD_DEFINES_VH

`define HMD_WORD_W 32
`define HMD_HALF_W 16
`define HMD_SUM_W 33
`define HMD_PROD_W 34

// operation family select
`define HMD_FAM_W 2
`define HMD_FAM_LOW_ACC 2'h0
`define HMD_FAM_NEG_CROSS 2'h1
`define HMD_FAM_NEG_HIGH 2'h2
`define HMD_FAM_RSVD 2'h3

// halfword positions, little-endian indices
`define HMD_LO_HI 15
`define HMD_LO_LO 0
`define HMD_HI_HI 31
`define HMD_HI_LO 16

// condition field zero layout: lt, gt, eq, summary overflow copy
`define HMD_CR_W 4
`define HMD_CR_LT 3
`define HMD_CR_GT 2
`define HMD_CR_EQ 1
`define HMD_CR_SO 0

// saturation values
`define HMD_SAT_POS 32'h7FFFFFFF
`define HMD_SAT_NEG 32'h80000000
`define HMD_SAT_UNS 32'hFFFFFFFF

// reset values
`define HMD_WORD_RST 32'h00000000
`define HMD_CR_RST 4'h0
`define HMD_BIT_RST 1'b0

`endif

/* File: logic/hmd_mac_arith.v */
// combinational multiply, accumulate and saturate stage
// assumes operands already chosen by the caller, no state here
`timescale 1ns/10ps
`include "hmd_defines.vh"

module hmd_mac_arith (
  input wire [`HMD_HALF_W-1:0] mult_a,
  input wire [`HMD_HALF_W-1:0] mult_b,
  input wire [`HMD_WORD_W-1:0] accum,
  input wire is_unsigned,
  input wire negate,
  input wire saturate,
  output reg [`HMD_WORD_W-1:0] result,
  output reg ovf
);

  wire signed [`HMD_HALF_W:0] a_ext;
  wire signed [`HMD_HALF_W:0] b_ext;
  wire signed [`HMD_PROD_W-1:0] prod;
  wire [`HMD_SUM_W-1:0] prod33;
  wire [`HMD_SUM_W-1:0] acc33;
  wire [`HMD_SUM_W-1:0] sum33;

  // one extra bit lets a single signed multiplier serve both signednesses
  assign a_ext = is_unsigned ? {1'b0, mult_a} : {mult_a[`HMD_HALF_W-1], mult_a}; // RL4
  assign b_ext = is_unsigned ? {1'b0, mult_b} : {mult_b[`HMD_HALF_W-1], mult_b}; // RL4
  assign prod = a_ext * b_ext;
  assign prod33 = prod[`HMD_SUM_W-1:0];
  assign acc33 = is_unsigned ? {1'b0, accum} : {accum[`HMD_WORD_W-1], accum};
  // negative forms subtract the product from the accumulator
  assign sum33 = negate ? (acc33 - prod33) : (acc33 + prod33); // RL1 RL10

  always @* begin
    if (is_unsigned) begin
      ovf = sum33[`HMD_SUM_W-1]; // RL14
    end else begin
      ovf = sum33[`HMD_SUM_W-1] ^ sum33[`HMD_WORD_W-1]; // RL14
    end
    if (saturate && ovf) begin
      if (is_unsigned) begin
        result = `HMD_SAT_UNS; // RL13
      end else if (sum33[`HMD_SUM_W-1]) begin
        result = `HMD_SAT_NEG; // RL13
      end else begin
        result = `HMD_SAT_POS; // RL13
      end
    end else begin
      result = sum33[`HMD_WORD_W-1:0]; // RL2 RL3
    end
  end

endmodule

/* File: testbench/hmd_mac_props.sv */
// port assertions for the mac datapath
// assumes a bind by port name from the bench top
`timescale 1ns/10ps
module hmd_mac_props (
  input wire clock, rst, clk_en, op_valid, op_unsigned, op_record, op_oe, xer_wr_en,
  input wire [1:0] op_family,
  input wire dest_we_q, cr0_we_q, xer_we_q, op_reject_q, overflow_flag_q, summary_overflow_q,
  input wire [31:0] dest_result_q,
  input wire [3:0] condition_field_zero_q
);
  wire go = clk_en && op_valid;
  wire lg = go && op_family != 2'h3 && !(op_unsigned && op_family != 2'h0);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_op_writes_dest: assert property (lg |=> dest_we_q && !op_reject_q)
    else $error("taken op gave no destination write");
  a_record_cr_we: assert property (lg |=> cr0_we_q == $past(op_record))
    else $error("condition field write does not follow record form");
  a_oe_xer_we: assert property (lg |=> xer_we_q == $past(op_oe))
    else $error("overflow write does not follow overflow form");
  a_bad_rejected: assert property (go && !lg |=> op_reject_q && !dest_we_q && !xer_we_q)
    else $error("illegal op not refused");
  a_idle_quiet: assert property (clk_en && !op_valid |=> !dest_we_q && !cr0_we_q)
    else $error("write pulse without op");
  a_so_sticky: assert property (clk_en && !xer_wr_en && summary_overflow_q |=> summary_overflow_q)
    else $error("summary overflow cleared by op");
  a_hold_flags: assert property (clk_en && !lg && !xer_wr_en |=> $stable(overflow_flag_q))
    else $error("overflow flag moved without op");
  a_ov_sets_so: assert property (xer_we_q && overflow_flag_q |-> summary_overflow_q)
    else $error("overflow without summary overflow");
  a_cr_so_copy: assert property (cr0_we_q |-> condition_field_zero_q[0] == summary_overflow_q)
    else $error("condition so bit differs");
  a_cr_sign: assert property (cr0_we_q |-> condition_field_zero_q[3] == dest_result_q[31])
    else $error("condition lt bit differs from result sign");
  c_reject: cover property (op_reject_q);
  c_sat: cover property (dest_we_q && dest_result_q == 32'h7FFFFFFF);
  c_ovf: cover property (xer_we_q && overflow_flag_q);
endmodule

/* File: testbench/hmd_core_model.sv */
// register file stand-in holding the accumulating destination
// assumes the bench preloads it and the datapath writes back into it
`timescale 1ns/10ps
module hmd_core_model (
  input wire clock, rst, ld, dest_we_q,
  input wire [31:0] ld_val, dest_result_q,
  output reg [31:0] dest_value
);
  always @(posedge clock) begin
    if (rst) dest_value <= 32'h00000000;
    else if (ld) dest_value <= ld_val;
    else if (dest_we_q) dest_value <= dest_result_q;
  end
endmodule

/* File: testbench/test_hmd_mac_datapath.sv */
// self-checking bench for the halfword mac datapath
// assumes the core model feeds the destination back each op
`timescale 1ns/10ps
module test_hmd_mac_datapath;
  reg clock = 0, rst = 1, clk_en = 1, op_valid = 0, op_unsigned = 0, op_saturate = 0;
  reg op_record = 0, op_oe = 0, xer_wr_en = 0, xer_wr_ov = 0, xer_wr_so = 0, ld = 0;
  reg [1:0] op_family = 0;
  reg [31:0] first_source_operand = 0, second_source_operand = 0, ld_val = 0, acc = 0, res = 0;
  reg [3:0] cr = 0;
  reg ov = 0, so = 0;
  wire [31:0] dest_value, dest_result_q;
  wire [3:0] condition_field_zero_q;
  wire dest_we_q, cr0_we_q, xer_we_q, overflow_flag_q, summary_overflow_q, op_reject_q;
  integer fail_count = 0, checks = 0, k;
  always #4 clock = ~clock;
  hmd_mac_datapath uut (.*);
  hmd_core_model cm (.*);
  task summarize;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string n, input [32:0] e, input [32:0] g);
    begin
      checks = checks + 1;
      if (e !== g) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  function [32:0] ex(input [1:0] f, input u, input s, input [31:0] a, input [31:0] b,
    input [31:0] d);
    reg [15:0] x, y;
    reg [31:0] p;
    reg [32:0] t;
    reg v;
    begin
      x = f == 2'h2 ? a[31:16] : a[15:0];
      y = f == 2'h0 ? b[15:0] : b[31:16];
      if (u) p = x * y;
      else p = $signed(x) * $signed(y);
      if (u) t = {1'b0, d} + {1'b0, p};
      else if (f != 2'h0) t = {d[31], d} - {p[31], p};
      else t = {d[31], d} + {p[31], p};
      v = u ? t[32] : t[32] != t[31];
      if (s && v) t[31:0] = u ? 32'hFFFFFFFF : (t[32] ? 32'h80000000 : 32'h7FFFFFFF);
      ex = {v, t[31:0]};
    end
  endfunction
  // preload needs its own edge so the model holds d before the op is taken
  task run(input p, input [1:0] f, input u, input s, input r, input o, input [31:0] a,
    input [31:0] b, input [31:0] d);
    reg [32:0] e;
    reg lg;
    begin
      if (p) begin
        ld <= 1;
        ld_val <= d;
        @(posedge clock);
        ld <= 0;
        acc = d;
      end
      lg = f != 2'h3 && !(u && f != 2'h0);
      e = ex(f, u, s, a, b, acc);
      op_valid <= 1;
      op_family <= f;
      {op_unsigned, op_saturate, op_record, op_oe} <= {u, s, r, o};
      first_source_operand <= a;
      second_source_operand <= b;
      @(posedge clock);
      op_valid <= 0;
      xer_wr_en <= 0;
      #1;
      if (lg) begin
        res = e[31:0];
        acc = res;
        if (o) ov = e[32];
        so = so | (o & ov);
        if (r) cr = {res[31], !res[31] && res != 0, res == 0, so};
      end
      chk("reject", !lg, op_reject_q);
      chk("we", {lg, lg & r, lg & o}, {dest_we_q, cr0_we_q, xer_we_q});
      chk("result", res, dest_result_q);
      chk("ov", {ov, so}, {overflow_flag_q, summary_overflow_q});
      chk("cr", cr, condition_field_zero_q);
      @(posedge clock);
    end
  endtask
  task t_walk;
    begin
      run(1, 2'h0, 0, 0, 1, 1, 32'h3, 32'h4, 32'h5);
      chk("walk", 12'h411, {condition_field_zero_q, dest_result_q[7:0]});
      run(0, 2'h0, 0, 0, 0, 0, 32'h3, 32'h4, 32'h0);
      chk("chain", 32'h1D, dest_result_q);
    end
  endtask
  task t_forms;
    for (k = 0; k < 4; k = k + 1) run(1, 2'h0, 0, 0, k[0], k[1], 1, 1, 32'h7FFFFFFF);
  endtask
  task t_sat;
    begin
      run(1, 2'h0, 1, 0, 0, 0, 32'hFFFF, 32'h2, 32'h1);
      run(1, 2'h1, 0, 0, 0, 0, 32'h50003, 32'h70002, 32'h64);
      run(1, 2'h2, 0, 0, 1, 0, 32'h50003, 32'hFFFE0002, 32'h0);
      run(1, 2'h0, 1, 1, 0, 1, 32'hFFFF, 32'hFFFF, 32'hFFFFFFFF);
      run(1, 2'h1, 0, 1, 0, 1, 32'h7FFF, 32'h7FFF0000, 32'h80000000);
      run(1, 2'h2, 0, 1, 1, 1, 32'h80000000, 32'h7FFF0000, 32'h7FFFFFFF);
      chk("sat", 32'h7FFFFFFF, dest_result_q);
    end
  endtask
  task t_reject;
    begin
      run(1, 2'h1, 1, 0, 1, 1, 32'h5, 32'h5, 32'h9);
      run(1, 2'h3, 0, 0, 1, 1, 32'h5, 32'h5, 32'h9);
    end
  endtask
  task t_xer;
    begin
      xer_wr_en <= 1;
      @(posedge clock);
      xer_wr_en <= 0;
      #1;
      {ov, so} = 2'b00;
      chk("xer", 0, {overflow_flag_q, summary_overflow_q});
      @(posedge clock);
      run(1, 2'h0, 0, 0, 0, 0, 32'h7FFF, 32'h7FFF, 32'h7FFFFFFF);
    end
  endtask
  // an op offered while the enable is low must leave no trace
  task t_freeze;
    begin
      clk_en <= 0;
      op_valid <= 1;
      op_family <= 2'h0;
      {op_record, op_oe} <= 2'b11;
      @(posedge clock);
      op_valid <= 0;
      clk_en <= 1;
      #1;
      chk("frz_res", res, dest_result_q);
      chk("frz_we", 0, {dest_we_q, cr0_we_q, xer_we_q});
      chk("frz_cr", cr, condition_field_zero_q);
      @(posedge clock);
    end
  endtask
  // software clear in the same cycle as an overflow form that overflows, then a software write setting overflow only
  task t_pair;
    begin
      xer_wr_en <= 1;
      {xer_wr_ov, xer_wr_so} <= 2'b00;
      run(0, 2'h1, 0, 0, 0, 1, 32'h7FFF, 32'h7FFF0000, 32'h0);
      xer_wr_en <= 1;
      {xer_wr_ov, xer_wr_so} <= 2'b10;
      @(posedge clock);
      xer_wr_en <= 0;
      #1;
      {ov, so} = 2'b10;
      chk("xer_set", {ov, so}, {overflow_flag_q, summary_overflow_q});
      @(posedge clock);
    end
  endtask
  task t_reset;
    begin
      rst <= 1;
      @(posedge clock);
      rst <= 0;
      #1;
      {res, cr, ov, so, acc} = 0;
      chk("rst_out", 0, {dest_we_q, cr0_we_q, xer_we_q, op_reject_q, overflow_flag_q,
        summary_overflow_q});
      chk("rst_res", 0, dest_result_q);
      chk("rst_cr", 0, condition_field_zero_q);
      run(0, 2'h0, 0, 0, 1, 1, 32'h3, 32'h4, 32'h0);
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    t_walk;
    t_forms;
    t_sat;
    t_reject;
    t_xer;
    t_freeze;
    t_pair;
    t_reset;
    summarize;
  end
  initial begin
    #5000;
    fail_count = fail_count + 1;
    summarize;
  end
endmodule
bind hmd_mac_datapath hmd_mac_props chk_props (.*);
